//--- rtl/codec_ctrl_pkg.sv
package codec_ctrl_pkg;

	// Clock and sample timing
	localparam longint CLK_HZ        = 100_000_000;
	localparam longint SAMPLE_HZ     = 8_000;
	localparam int     SAMPLE_CYCLES = int'(CLK_HZ / SAMPLE_HZ);
	// Tone frequency step in micro-hertz (7.8125 Hz)
	localparam longint TONE_STEP_UHZ = 7_812_500;
	localparam int     PHASE_W       = $clog2(int'(SAMPLE_HZ * 1_000_000 / TONE_STEP_UHZ));

	// Register addresses
	localparam logic [7:0] ADDR_POWER     = 8'h00;
	localparam logic [7:0] ADDR_MODE      = 8'h01;
	localparam logic [7:0] ADDR_TX_ST     = 8'h02;
	localparam logic [7:0] ADDR_RX_VOL    = 8'h03;
	localparam logic [7:0] ADDR_HIGH_TONE = 8'h04;
	localparam logic [7:0] ADDR_LOW_TONE  = 8'h05;

	// Reset values
	localparam logic [7:0] POWER_RST = 8'h00;
	localparam logic [7:0] MODE_RST  = 8'h02;
	localparam logic [7:0] TX_ST_RST = 8'h40;
	localparam logic [7:0] RX_VOL_RST = 8'h70;
	localparam logic [7:0] TONE_RST  = 8'h00;

	// Power control fields
	localparam int PWR_EAR1_SEL_BIT = 1;
	localparam int PWR_EAR_MUTE_BIT = 3;
	localparam int PWR_MIC_MUTE_BIT = 6;
	localparam int PWR_ST_MUTE_BIT  = 7;
	// Mode control fields
	localparam int MODE_BUZZ_BIT    = 3;
	localparam int MODE_COMPAND_BIT = 4;
	localparam int MODE_TONE_BIT    = 6;
	// Transmit/sidetone and receive/volume fields
	localparam int ST_LSB = 0;
	localparam int TP_LSB = 3;
	localparam int RV_LSB = 0;
	localparam int RP_LSB = 4;

	// Gain code limits and steps
	localparam logic [3:0] TX_EXT_LAST   = 4'h5;
	localparam logic [3:0] TX_NORM_FIRST = 4'h8;
	localparam logic [3:0] TX_NORM_LAST  = 4'hd;
	localparam logic [3:0] TX_STEP_DB    = 4'h2;
	localparam logic [4:0] TX_EXTRA_DB   = 5'h0c;
	localparam logic [3:0] RX_LAST       = 4'hc;
	localparam logic [4:0] RX_TOP_DB     = 5'h06;
	localparam logic [2:0] ST_LAST       = 3'h6;
	localparam logic [4:0] ST_BASE_DB    = 5'h0c;
	localparam logic [3:0] VOL_LAST      = 4'h9;

	// Serial word lengths
	localparam int COMPAND_BITS = 8;
	localparam int LINEAR_BITS  = 15;

	// Tone amplitudes, high one about 2 dB above low one
	localparam logic signed [7:0] LOW_AMP  = 8'sh1f;
	localparam logic signed [7:0] HIGH_AMP = 8'sh27;
	localparam logic signed [10:0] PDM_FULL = 11'sh050;

	typedef enum {RX_IDLE, RX_SHIFT, RX_HOLD} rx_state_t;

endpackage

//--- rtl/word_stream_if.sv
`timescale 1ns/1ps
interface word_stream_if #(parameter int W = 16);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

//--- rtl/tone_channel.sv
`timescale 1ns/1ps
module tone_channel import codec_ctrl_pkg::*; #(
	parameter logic signed [7:0] AMP = LOW_AMP
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// Control
	input  wire logic              tick,
	input  wire logic              enable,
	input  wire logic [7:0]        tone_value,
	// Tone level
	output logic signed [7:0]      level
);

	logic [PHASE_W-1:0] phase;

	// Phase steps by the value each sample, so frequency is value times step
	always_ff @(posedge clk) begin
		if (rst) begin
			phase <= '0;
		end else if (tick) begin
			phase <= phase + PHASE_W'(tone_value);
		end
	end

	// Square wave keeps the block table-free; shaping is left to the analog filter
	always_ff @(posedge clk) begin
		if (rst || !enable || tone_value == 8'h00) begin
			level <= 8'sh00;
		end else begin
			level <= phase[PHASE_W-1] ? -AMP : AMP;
		end
	end

endmodule

//--- rtl/word_buffer.sv
`timescale 1ns/1ps
module word_buffer #(
	parameter int W     = 16,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Filling and draining sides
	word_stream_if.snk fill,
	word_stream_if.src drain
);

	localparam int CW = $clog2(DEPTH + 1);

	initial begin
		if (DEPTH < 1) $error("word_buffer needs DEPTH of at least one");
	end

	logic [W-1:0]  mem [DEPTH];
	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic          has_word;
	logic          push;
	logic          pop;

	assign fill.ready  = (count != CW'(DEPTH));
	assign push        = fill.valid && fill.ready;
	assign pop         = has_word && drain.ready;
	assign next_count  = count + CW'(push) - CW'(pop);
	assign drain.valid = has_word; // Straight from a flop, no compare on the output
	assign drain.data  = mem[0];

	// Occupancy, with the non-empty flag kept in its own flop
	always_ff @(posedge clk) begin
		if (rst) begin
			count    <= '0;
			has_word <= 1'b0;
		end else begin
			count    <= next_count;
			has_word <= (next_count != '0);
		end
	end

	// Shift storage so the head always sits in a flop
	always_ff @(posedge clk) begin
		for (int i = 0; i < DEPTH; i++) begin
			if (push && (int'(count) - int'(pop)) == i) begin
				mem[i] <= fill.data;
			end else if (pop && i < DEPTH - 1) begin
				mem[i] <= mem[i+1];
			end
		end
	end

endmodule

//--- rtl/gain_pcm_tone_control.sv
`timescale 1ns/1ps
// Behaviour
// - Transmit code picks extended or normal, 2 dB steps
// - Reset transmit code 1000, 23.5 dB total
// - Receive code 0 gives +6, 1 dB steps
// - Reset receive code 0111, -1 dB
// - Sidetone code 0 gives -12, 2 dB steps
// - Reset sidetone code 000, -12 dB
// - Power bit 7 mutes sidetone
// - Volume code 0 gives 0, 2 dB steps
// - Reset volume code 0000, 0 dB
// - Exactly one earphone stage drives at once
// - Power bit 3 mutes earphone
// - Companded word: 8 bits, MSB first
// - Linear word: 15 bits MSB first, slot 16 unused
// - Tone registers 8 bits, value times step
// - High tone 2 dB louder than low
// - Tones summed, also feed buzzer output
// - Linear words are 15-bit two's complement
module gain_pcm_tone_control import codec_ctrl_pkg::*; #(
	parameter int SAMPLE_DIV = SAMPLE_CYCLES
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// Register port
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	input  wire logic [7:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	output logic [7:0]             reg_rdata,
	output logic                   reg_rvalid,
	// Serial receive pins
	input  wire logic              pcm_bclk,
	input  wire logic              pcm_sync,
	input  wire logic              pcm_din,
	// Received words
	output logic                   rx_valid,
	input  wire logic              rx_ready,
	output logic [14:0]            rx_word,
	output logic                   rx_linear,
	output logic                   rx_overrun,
	// Decoded gains
	output logic                   tx_extended,
	output logic [3:0]             tx_pga_atten_db,
	output logic                   tx_code_valid,
	output logic                   mic_muted,
	output logic signed [4:0]      rx_gain_db,
	output logic                   rx_code_valid,
	output logic [4:0]             sidetone_atten_db,
	output logic                   sidetone_muted,
	output logic [4:0]             volume_atten_db,
	output logic                   volume_code_valid,
	// Earphone stages
	output logic                   diff_ear_out_pos,
	output logic                   diff_ear_out_neg,
	output logic                   single_ear_out,
	output logic                   ear_muted,
	// Tone outputs
	output logic signed [8:0]      dual_tone,
	output logic                   buzzer_pdm_out
);

	initial begin
		if (SAMPLE_DIV < 2) $error("SAMPLE_DIV must be at least two");
	end

	localparam int DW = $clog2(SAMPLE_DIV);

	// Register storage
	logic [7:0] power_ctrl;
	logic [7:0] mode_ctrl;
	logic [7:0] tx_sidetone;
	logic [7:0] rx_volume;
	logic [7:0] high_tone_select;
	logic [7:0] low_tone_select;

	// Register writes; unmapped addresses are ignored
	always_ff @(posedge clk) begin
		if (rst) begin
			power_ctrl       <= POWER_RST;
			mode_ctrl        <= MODE_RST;
			tx_sidetone      <= TX_ST_RST;
			rx_volume        <= RX_VOL_RST;
			high_tone_select <= TONE_RST;
			low_tone_select  <= TONE_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				ADDR_POWER:     power_ctrl       <= reg_wdata;
				ADDR_MODE:      mode_ctrl        <= reg_wdata;
				ADDR_TX_ST:     tx_sidetone      <= reg_wdata;
				ADDR_RX_VOL:    rx_volume        <= reg_wdata;
				ADDR_HIGH_TONE: high_tone_select <= reg_wdata;
				ADDR_LOW_TONE:  low_tone_select  <= reg_wdata;
				default:        ;
			endcase
		end
	end

	// Read back, one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				case (reg_addr)
					ADDR_POWER:     reg_rdata <= power_ctrl;
					ADDR_MODE:      reg_rdata <= mode_ctrl;
					ADDR_TX_ST:     reg_rdata <= tx_sidetone;
					ADDR_RX_VOL:    reg_rdata <= rx_volume;
					ADDR_HIGH_TONE: reg_rdata <= high_tone_select;
					ADDR_LOW_TONE:  reg_rdata <= low_tone_select;
					default:        reg_rdata <= 8'h00;
				endcase
			end
		end
	end

	// Field views
	logic [3:0] tx_code;
	logic [2:0] st_code;
	logic [3:0] rx_code;
	logic [3:0] vol_code;
	assign tx_code  = tx_sidetone[TP_LSB +: 4];
	assign st_code  = tx_sidetone[ST_LSB +: 3];
	assign rx_code  = rx_volume[RP_LSB +: 4];
	assign vol_code = rx_volume[RV_LSB +: 4];

	// Transmit gain decode; undefined codes hold attenuation at zero
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_extended     <= 1'b0;
			tx_pga_atten_db <= 4'h0;
			tx_code_valid   <= 1'b1;
		end else if (tx_code <= TX_EXT_LAST) begin
			tx_extended     <= 1'b1;
			tx_pga_atten_db <= 4'(tx_code * TX_STEP_DB);
			tx_code_valid   <= 1'b1;
		end else if (tx_code >= TX_NORM_FIRST && tx_code <= TX_NORM_LAST) begin
			tx_extended     <= 1'b0;
			tx_pga_atten_db <= 4'((tx_code - TX_NORM_FIRST) * TX_STEP_DB);
			tx_code_valid   <= 1'b1;
		end else begin
			tx_extended     <= 1'b0;
			tx_pga_atten_db <= 4'h0;
			tx_code_valid   <= 1'b0;
		end
	end

	// Receive gain, +6 dB falling 1 dB per code
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_gain_db    <= 5'sh00;
			rx_code_valid <= 1'b1;
		end else begin
			rx_code_valid <= (rx_code <= RX_LAST);
			if (rx_code <= RX_LAST) begin
				rx_gain_db <= $signed(RX_TOP_DB - {1'b0, rx_code});
			end else begin
				rx_gain_db <= 5'sh00;
			end
		end
	end

	// Sidetone and mic mute; code 111 is clamped to the last step
	always_ff @(posedge clk) begin
		if (rst) begin
			sidetone_atten_db <= ST_BASE_DB;
			sidetone_muted    <= 1'b0;
			mic_muted         <= 1'b0;
		end else begin
			if (st_code <= ST_LAST) begin
				sidetone_atten_db <= ST_BASE_DB + {1'b0, st_code, 1'b0};
			end else begin
				sidetone_atten_db <= ST_BASE_DB + {1'b0, ST_LAST, 1'b0};
			end
			sidetone_muted <= power_ctrl[PWR_ST_MUTE_BIT];
			mic_muted      <= power_ctrl[PWR_MIC_MUTE_BIT];
		end
	end

	// Volume; codes above the last step are clamped and flagged
	always_ff @(posedge clk) begin
		if (rst) begin
			volume_atten_db   <= 5'h00;
			volume_code_valid <= 1'b1;
		end else begin
			volume_code_valid <= (vol_code <= VOL_LAST);
			if (vol_code <= VOL_LAST) begin
				volume_atten_db <= {vol_code, 1'b0};
			end else begin
				volume_atten_db <= {VOL_LAST, 1'b0};
			end
		end
	end

	// Earphone routing; the two stage enables are complements by construction
	always_ff @(posedge clk) begin
		if (rst) begin
			diff_ear_out_pos <= 1'b0;
			diff_ear_out_neg <= 1'b0;
			single_ear_out   <= 1'b1;
			ear_muted        <= 1'b0;
		end else begin
			diff_ear_out_pos <= power_ctrl[PWR_EAR1_SEL_BIT];
			diff_ear_out_neg <= power_ctrl[PWR_EAR1_SEL_BIT];
			single_ear_out   <= !power_ctrl[PWR_EAR1_SEL_BIT];
			ear_muted        <= power_ctrl[PWR_EAR_MUTE_BIT];
		end
	end

	// Serial pins pass two flops; a third flop gives the clock edge
	logic [1:0] bclk_sync;
	logic [1:0] fs_sync;
	logic [1:0] din_sync;
	logic       bclk_prev;
	always_ff @(posedge clk) begin
		if (rst) begin
			bclk_sync <= 2'b00;
			fs_sync   <= 2'b00;
			din_sync  <= 2'b00;
			bclk_prev <= 1'b0;
		end else begin
			bclk_sync <= {bclk_sync[0], pcm_bclk};
			fs_sync   <= {fs_sync[0], pcm_sync};
			din_sync  <= {din_sync[0], pcm_din};
			bclk_prev <= bclk_sync[1];
		end
	end

	logic bclk_rise;
	assign bclk_rise = bclk_sync[1] && !bclk_prev;

	// Deserialiser
	word_stream_if #(.W(16)) in_if ();
	word_stream_if #(.W(16)) out_if ();

	rx_state_t   rx_state;
	logic [3:0]  bit_count;
	logic [14:0] shift;
	logic        word_linear;
	logic [3:0]  last_slot;
	assign last_slot = mode_ctrl[MODE_COMPAND_BIT] ? 4'(COMPAND_BITS - 1)
	                                               : 4'(LINEAR_BITS - 1);

	// Slot one starts with frame sync; bits past the word, slot 16 too, are ignored
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_state    <= RX_IDLE;
			bit_count   <= 4'h0;
			shift       <= 15'h0000;
			word_linear <= 1'b0;
			rx_overrun  <= 1'b0;
		end else begin
			case (rx_state)
				RX_IDLE: begin
					if (bclk_rise && fs_sync[1]) begin
						shift       <= {14'h0000, din_sync[1]};
						bit_count   <= 4'h1;
						word_linear <= !mode_ctrl[MODE_COMPAND_BIT];
						rx_state    <= RX_SHIFT;
					end
				end
				RX_SHIFT: begin
					if (bit_count > last_slot) begin
						rx_state <= RX_HOLD;
					end else if (bclk_rise) begin
						shift     <= {shift[13:0], din_sync[1]};
						bit_count <= bit_count + 4'h1;
					end
				end
				RX_HOLD: begin
					// Pin source cannot stall, so a sync while full is counted lost
					if (in_if.ready) begin
						rx_state <= RX_IDLE;
					end else if (bclk_rise && fs_sync[1]) begin
						rx_overrun <= 1'b1;
					end
				end
				default: rx_state <= RX_IDLE;
			endcase
		end
	end

	// Companded words sit in the low byte; linear words are signed 15-bit
	assign in_if.valid = (rx_state == RX_HOLD);
	assign in_if.data  = {word_linear, shift};

	word_buffer #(.W(16), .DEPTH(2)) u_rx_buffer (
		.clk   (clk),
		.rst   (rst),
		.fill  (in_if),
		.drain (out_if)
	);

	assign out_if.ready = rx_ready;
	assign rx_valid     = out_if.valid;
	assign rx_word      = out_if.data[14:0];
	assign rx_linear    = out_if.data[15];

	// Sample tick for the tone phase accumulators
	logic [DW-1:0] div_count;
	logic          tick;
	always_ff @(posedge clk) begin
		if (rst) begin
			div_count <= '0;
			tick      <= 1'b0;
		end else begin
			tick <= (div_count == DW'(SAMPLE_DIV - 1));
			if (div_count == DW'(SAMPLE_DIV - 1)) begin
				div_count <= '0;
			end else begin
				div_count <= div_count + DW'(1);
			end
		end
	end

	// Tone channels; larger amplitude on the high register
	logic signed [7:0] high_level;
	logic signed [7:0] low_level;

	tone_channel #(.AMP(HIGH_AMP)) u_high_tone (
		.clk        (clk),
		.rst        (rst),
		.tick       (tick),
		.enable     (mode_ctrl[MODE_TONE_BIT]),
		.tone_value (high_tone_select),
		.level      (high_level)
	);

	tone_channel #(.AMP(LOW_AMP)) u_low_tone (
		.clk        (clk),
		.rst        (rst),
		.tick       (tick),
		.enable     (mode_ctrl[MODE_TONE_BIT]),
		.tone_value (low_tone_select),
		.level      (low_level)
	);

	// Dual-tone sum
	always_ff @(posedge clk) begin
		if (rst) begin
			dual_tone <= 9'sh000;
		end else begin
			dual_tone <= 9'(high_level) + 9'(low_level);
		end
	end

	// First-order density modulator drives the buzzer from the same sum
	logic signed [10:0] pdm_acc;
	logic signed [10:0] next_pdm_acc;
	always_comb begin
		next_pdm_acc = pdm_acc + 11'(dual_tone) - (buzzer_pdm_out ? PDM_FULL : -PDM_FULL);
	end

	always_ff @(posedge clk) begin
		if (rst || !mode_ctrl[MODE_BUZZ_BIT]) begin
			pdm_acc        <= 11'sh000;
			buzzer_pdm_out <= 1'b0;
		end else begin
			pdm_acc        <= next_pdm_acc;
			buzzer_pdm_out <= (next_pdm_acc >= 11'sh000);
		end
	end

endmodule

//--- tb/gain_pcm_tone_control_monitor.sv
`timescale 1ns/1ps
module gain_pcm_tone_control_monitor (
	// Clock and reset
	input wire logic              clk,
	input wire logic              rst,
	// Register port
	input wire logic              reg_wr,
	input wire logic [7:0]        reg_addr,
	input wire logic [7:0]        reg_wdata,
	// Received words
	input wire logic              rx_valid,
	input wire logic              rx_ready,
	input wire logic [14:0]       rx_word,
	// Decoded gains and stages
	input wire logic              tx_extended,
	input wire logic [3:0]        tx_pga_atten_db,
	input wire logic signed [4:0] rx_gain_db,
	input wire logic [4:0]        sidetone_atten_db,
	input wire logic              sidetone_muted,
	input wire logic [4:0]        volume_atten_db,
	input wire logic              diff_ear_out_pos,
	input wire logic              single_ear_out,
	input wire logic              ear_muted
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Per-register write strobes; decoded outputs follow two edges later
	logic wr_pwr;
	logic wr_txst;
	logic wr_rxvol;
	assign wr_pwr   = reg_wr && reg_addr == 8'h00;
	assign wr_txst  = reg_wr && reg_addr == 8'h02;
	assign wr_rxvol = reg_wr && reg_addr == 8'h03;

	a_one_ear_stage: assert property (diff_ear_out_pos != single_ear_out)
		else $error("earphone stage select not exclusive");
	a_ear_mute_follow: assert property (wr_pwr |-> ##2 ear_muted == $past(reg_wdata[3], 2))
		else $error("earphone mute does not follow power bit");
	a_st_mute_follow: assert property (wr_pwr |-> ##2 sidetone_muted == $past(reg_wdata[7], 2))
		else $error("sidetone mute does not follow power bit");
	a_rx_gain_step: assert property ((wr_rxvol && reg_wdata[7:4] <= 4'hc) |->
		##2 rx_gain_db == 5'(6 - $past(reg_wdata[7:4], 2)))
		else $error("receive gain decode wrong");
	a_vol_step: assert property ((wr_rxvol && reg_wdata[3:0] <= 4'h9) |->
		##2 volume_atten_db == 5'($past(reg_wdata[3:0], 2) * 2))
		else $error("volume decode wrong");
	a_st_step: assert property ((wr_txst && reg_wdata[2:0] <= 3'h6) |->
		##2 sidetone_atten_db == 5'(12 + $past(reg_wdata[2:0], 2) * 2))
		else $error("sidetone decode wrong");
	a_tx_mode_step: assert property ((wr_txst && (reg_wdata[6:3] <= 4'h5 ||
		(reg_wdata[6:3] >= 4'h8 && reg_wdata[6:3] <= 4'hd))) |-> ##2
		(tx_extended == !$past(reg_wdata[6], 2) &&
		tx_pga_atten_db == 4'($past(reg_wdata[5:3], 2) * 2)))
		else $error("transmit mode decode wrong");
	a_reset_defaults: assert property ($fell(rst) |=> (rx_gain_db == -5'sd1 &&
		volume_atten_db == 5'h00 && sidetone_atten_db == 5'h0c &&
		!tx_extended && tx_pga_atten_db == 4'h0))
		else $error("decoded defaults wrong after reset");
	a_rx_word_hold: assert property ((rx_valid && !rx_ready) |=> (rx_valid && $stable(rx_word)))
		else $error("stalled word lost or changed");
endmodule

bind gain_pcm_tone_control gain_pcm_tone_control_monitor mon (
	.clk, .rst, .reg_wr, .reg_addr, .reg_wdata, .rx_valid, .rx_ready, .rx_word,
	.tx_extended, .tx_pga_atten_db, .rx_gain_db, .sidetone_atten_db, .sidetone_muted,
	.volume_atten_db, .diff_ear_out_pos, .single_ear_out, .ear_muted
);

//--- tb/pcm_source.sv
`timescale 1ns/1ps
module pcm_source (
	// Clock
	input wire logic clk,
	// Serial pins
	output logic     pcm_bclk,
	output logic     pcm_sync,
	output logic     pcm_din
);
	// Four cycles per phase leaves margin over the two-flop synchroniser
	localparam int HALF = 4;

	// Pins idle with the bit clock stopped low
	initial begin
		pcm_bclk = 1'b0;
		pcm_sync = 1'b0;
		pcm_din  = 1'b0;
	end

	// One frame, MSB first; slots past nbits carry junk
	task automatic send(input logic [14:0] word, input int nbits, input int slots);
		for (int i = 0; i < slots; i++) begin
			@(posedge clk);
			pcm_sync <= (i == 0);
			pcm_din  <= (i < nbits) ? word[nbits-1-i] : ~pcm_din;
			repeat (HALF) @(posedge clk);
			pcm_bclk <= 1'b1;
			repeat (HALF) @(posedge clk);
			pcm_bclk <= 1'b0;
		end
		// Released data line must not keep the last bit
		@(posedge clk);
		pcm_sync <= 1'b0;
		pcm_din  <= ~pcm_din;
	endtask
endmodule

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
	typedef struct packed {
		logic [7:0] tx_st;
		logic [7:0] rx_vol;
		logic       ext;
		logic [3:0] att;
		logic [4:0] st;
		logic [4:0] rx;
		logic [4:0] vol;
	} row_t;

	logic               clk;
	logic               rst;
	logic               reg_wr;
	logic               reg_rd;
	logic [7:0]         reg_addr;
	logic [7:0]         reg_wdata;
	logic [7:0]         reg_rdata;
	logic               reg_rvalid;
	logic               pcm_bclk;
	logic               pcm_sync;
	logic               pcm_din;
	logic               rx_valid;
	logic               rx_ready;
	logic [14:0]        rx_word;
	logic               rx_linear;
	logic               rx_overrun;
	logic               tx_extended;
	logic [3:0]         tx_pga_atten_db;
	logic               tx_code_valid;
	logic               mic_muted;
	logic signed [4:0]  rx_gain_db;
	logic               rx_code_valid;
	logic [4:0]         sidetone_atten_db;
	logic               sidetone_muted;
	logic [4:0]         volume_atten_db;
	logic               volume_code_valid;
	logic               diff_ear_out_pos;
	logic               diff_ear_out_neg;
	logic               single_ear_out;
	logic               ear_muted;
	logic signed [8:0]  dual_tone;
	logic               buzzer_pdm_out;
	int                 bad_count = 0;
	int                 check_count = 0;
	int                 ones;
	logic [7:0]         rst_vals [7] = '{8'h00, 8'h02, 8'h40, 8'h70, 8'h00, 8'h00, 8'h00};
	logic [14:0]        lin [4] = '{15'h4321, 15'h0abc, 15'h7ffe, 15'h1234};
	// Register codes beside the decoded values they must give
	row_t               rows [6] = '{
		'{8'h00, 8'h00, 1'b1, 4'h0, 5'h0c, 5'h06, 5'h00},
		'{8'h2e, 8'hc9, 1'b1, 4'ha, 5'h18, 5'h1a, 5'h12},
		'{8'h41, 8'h71, 1'b0, 4'h0, 5'h0e, 5'h1f, 5'h02},
		'{8'h6b, 8'h35, 1'b0, 4'ha, 5'h12, 5'h03, 5'h0a},
		'{8'h4d, 8'ha4, 1'b0, 4'h2, 5'h16, 5'h1c, 5'h08},
		'{8'h14, 8'h56, 1'b1, 4'h4, 5'h14, 5'h01, 5'h0c}
	};

	// Short tone period keeps the tone checks brief
	gain_pcm_tone_control #(.SAMPLE_DIV(8)) dut (
		.clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
		.pcm_bclk, .pcm_sync, .pcm_din, .rx_valid, .rx_ready, .rx_word, .rx_linear,
		.rx_overrun, .tx_extended, .tx_pga_atten_db, .tx_code_valid, .mic_muted,
		.rx_gain_db, .rx_code_valid, .sidetone_atten_db, .sidetone_muted,
		.volume_atten_db, .volume_code_valid, .diff_ear_out_pos, .diff_ear_out_neg,
		.single_ear_out, .ear_muted, .dual_tone, .buzzer_pdm_out
	);
	pcm_source src (.clk, .pcm_bclk, .pcm_sync, .pcm_din);

	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Verdict and end of run
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Write, then let the decoded outputs settle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr    <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd   <= 1'b0;
		@(negedge clk);
		chk({reg_rvalid, reg_rdata}, {1'b1, exp});
	endtask

	task automatic check_dec(input row_t r);
		chk({tx_extended, tx_pga_atten_db}, {r.ext, r.att});
		chk({sidetone_atten_db, rx_gain_db, volume_atten_db}, {r.st, r.rx, r.vol});
		chk({tx_code_valid, rx_code_valid, volume_code_valid}, 3'b111);
	endtask

	// Bounded wait for a word, compare, then hand one ready pulse
	task automatic take(input logic [15:0] exp);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (rx_valid !== 1'b1 && n < 3000);
		if (n >= 3000) begin
			bad_count++;
			$display("CHECK FAILED at %0t: no received word", $time);
			complete_run();
		end
		chk({rx_linear, rx_word}, exp);
		@(posedge clk);
		rx_ready <= 1'b1;
		@(posedge clk);
		rx_ready <= 1'b0;
	endtask

	task automatic settle_tone();
		repeat (40) @(posedge clk);
		#1;
	endtask

	// Main sequence
	initial begin
		rst       = 1'b1;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_addr  = 8'h00;
		reg_wdata = 8'h00;
		rx_ready  = 1'b0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		check_dec('{8'h40, 8'h70, 1'b0, 4'h0, 5'h0c, 5'h1f, 5'h00});
		for (int a = 0; a < 7; a++)
			rd(8'(a), rst_vals[a]);
		wr(8'h04, 8'hab);
		rd(8'h04, 8'hab);
		$display("test reset_and_regs done");
		foreach (rows[i]) begin
			wr(8'h02, rows[i].tx_st);
			wr(8'h03, rows[i].rx_vol);
			check_dec(rows[i]);
		end
		$display("test gain_rows done");
		// Undefined codes: transmit, receive and volume flagged, transmit and receive zeroed, others clamped
		wr(8'h02, 8'h37);
		wr(8'h03, 8'hdf);
		chk({tx_code_valid, tx_extended, tx_pga_atten_db}, 6'h00);
		chk({rx_code_valid, rx_gain_db, volume_code_valid}, 7'h00);
		chk({sidetone_atten_db, volume_atten_db}, {5'h18, 5'h12});
		$display("test undefined_codes done");
		wr(8'h00, 8'hca);
		chk({mic_muted, sidetone_muted, ear_muted, diff_ear_out_pos, diff_ear_out_neg,
			single_ear_out}, 6'b111110);
		wr(8'h00, 8'h00);
		chk({mic_muted, sidetone_muted, ear_muted, diff_ear_out_pos, diff_ear_out_neg,
			single_ear_out}, 6'b000001);
		$display("test power_bits done");
		wr(8'h04, 8'h9b);
		wr(8'h01, 8'h42);
		settle_tone();
		chk(dual_tone == 9'sd39 || dual_tone == -9'sd39, 1'b1);
		chk(buzzer_pdm_out, 1'b0);
		wr(8'h05, 8'h59);
		settle_tone();
		chk(dual_tone inside {9'sd70, 9'sd8, -9'sd8, -9'sd70}, 1'b1);
		wr(8'h04, 8'h00);
		settle_tone();
		chk(dual_tone == 9'sd31 || dual_tone == -9'sd31, 1'b1);
		// Buzzer enabled: a live tone must give both levels in the stream
		wr(8'h01, 8'h4a);
		ones = 0;
		repeat (40) begin
			@(posedge clk);
			#1;
			ones += int'(buzzer_pdm_out);
		end
		chk(ones > 0 && ones < 40, 1'b1);
		$display("test tones done");
		wr(8'h01, 8'h12);
		src.send(15'h00a5, 8, 8);
		take(16'h00a5);
		wr(8'h01, 8'h02);
		foreach (lin[i])
			src.send(lin[i], 15, 16);
		chk(rx_overrun, 1'b1);
		for (int i = 0; i < 3; i++)
			take({1'b1, lin[i]});
		$display("test serial_words done");
		// Reset in mid-run clears the sticky flag and restores defaults
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk({rx_overrun, rx_valid}, 2'b00);
		check_dec('{8'h40, 8'h70, 1'b0, 4'h0, 5'h0c, 5'h1f, 5'h00});
		rd(8'h03, 8'h70);
		$display("test mid_reset done");
		complete_run();
	end
endmodule
